// *** core/dmcc_params.svh ***
// constants for the dma channel mode control block
`ifndef DMCC_PARAMS_SVH
`define DMCC_PARAMS_SVH
`define DMCC_OFS_CTRL      12'h000
`define DMCC_OFS_SRC       12'h004
`define DMCC_OFS_GLOBAL    12'h008
`define DMCC_OFS_SADDR     12'h00c
`define DMCC_OFS_COUNT     12'h010
`define DMCC_OFS_STATUS    12'h014
`define DMCC_BIT_DE        0
`define DMCC_BIT_TE        1
`define DMCC_BIT_IE        2
`define DMCC_BIT_TA        3
`define DMCC_BIT_TB        4
`define DMCC_BIT_DL        5
`define DMCC_BIT_DS        6
`define DMCC_BIT_AL        7
`define DMCC_BIT_AM        8
`define DMCC_BIT_AR        9
`define DMCC_TS_LO         10
`define DMCC_TS_HI         11
`define DMCC_SM_LO         12
`define DMCC_SM_HI         13
`define DMCC_CTRL_WMASK    16'hfffd
`define DMCC_CTRL_RESET    16'h0000
`define DMCC_SRC_RESET     2'h0
`define DMCC_COUNT_W       24
`define DMCC_BEATS_16B     2'h3
`define DMCC_STEP_1        32'h00000001
`define DMCC_STEP_2        32'h00000002
`define DMCC_STEP_4        32'h00000004
`define DMCC_STEP_16       32'h00000010
`endif

// *** core/dmcc_pkg.sv ***
// types for the dma channel mode control block
package dmcc_pkg;
    typedef enum logic [1:0] {DMCC_SM_FIXED, DMCC_SM_INC, DMCC_SM_DEC, DMCC_SM_RSVD} dmcc_step_type;
    typedef enum logic [1:0] {DMCC_TS_BYTE, DMCC_TS_WORD, DMCC_TS_LONG, DMCC_TS_16B} dmcc_size_type;
    typedef enum logic [1:0] {DMCC_RS_PIN, DMCC_RS_RXFULL, DMCC_RS_TXEMPTY, DMCC_RS_RSVD} dmcc_src_type;
endpackage

// *** core/dmcc_req_detect.sv ***
// external request detection: level or edge, either polarity
`timescale 1ns/1ps
module dmcc_req_detect
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // configuration
    input  wire logic sense_edge,
    input  wire logic active_high,
    // request in and detected request out
    input  wire logic req_in,
    output logic      req_hit
);
    logic prev;
    logic norm;
    logic norm_prev;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prev <= 1'b0;
        else
            prev <= req_in;
    end

    always_comb
    begin
        // fold polarity so that one is always the active level
        norm      = active_high ? req_in : ~req_in;
        norm_prev = active_high ? prev : ~prev;
        if (sense_edge)
            req_hit = norm & ~norm_prev;
        else
            req_hit = norm;
    end
endmodule // dmcc_req_detect

// *** core/dmcc_addr_step.sv ***
// source address step for one completed transfer
`timescale 1ns/1ps
`include "dmcc_params.svh"
module dmcc_addr_step
(
    // mode and size
    input  wire dmcc_pkg::dmcc_step_type mode,
    input  wire dmcc_pkg::dmcc_size_type size,
    // address in and out
    input  wire logic [31:0]             addr_in,
    output logic [31:0]                  addr_out
);
    import dmcc_pkg::*;
    logic [31:0] step;

    always_comb
    begin
        case (size)
            DMCC_TS_BYTE: step = `DMCC_STEP_1;
            DMCC_TS_WORD: step = `DMCC_STEP_2;
            DMCC_TS_LONG: step = `DMCC_STEP_4;
            default:      step = `DMCC_STEP_16;
        endcase
        case (mode)
            DMCC_SM_INC: addr_out = addr_in + step;
            // decrement stops at longword; 16-byte units still climb
            DMCC_SM_DEC: addr_out = (size == DMCC_TS_16B) ? addr_in + step : addr_in - step;
            // fixed mode still advances over a 16-byte block
            DMCC_SM_FIXED: addr_out = (size == DMCC_TS_16B) ? addr_in + step : addr_in;
            // reserved encoding holds the address, software must not use it
            default:     addr_out = addr_in;
        endcase
    end
endmodule // dmcc_addr_step

// *** core/dmcc_channel.sv ***
// one dma channel mode control with ahb-lite register slave
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "dmcc_params.svh"
// How it works
// - fixed source holds, but 16-byte adds 16
// - increment mode adds 1,2,4 or 16
// - decrement subtracts 1,2,4; 16-byte adds 16
// - size byte/word/long/16-byte as four longwords
// - request bit picks module or auto request
// - phase bit puts ack in read/write cycle
// - polarity bit makes ack low or high
// - sense level/edge, polarity low/high
// - bus mode cycle-steal releases, burst holds
// - address bit selects single address mode
// - interrupt raised only when enable bit set
// - done flag set only on count zero
// - done flag cleared by read-1 then write-0
// - source selects pin, receive-full or transmit-empty
// - count register holds remaining transfers, decrements
// - global master enable gates this one channel
module dmcc_channel
(
    // ahb-lite clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // request sources
    input  wire logic        external_request_pin,
    input  wire logic        serial_rx_full_req,
    input  wire logic        serial_tx_empty_req,
    // transfer engine side
    input  wire logic        xfer_done,
    input  wire logic        xfer_abort,
    output logic             xfer_start,
    output logic             xfer_is_write,
    output logic [31:0]      xfer_src_addr,
    output logic             bus_hold,
    output logic             single_address,
    // peripheral acknowledge and interrupt
    output logic             dma_acknowledge_pin,
    output logic             channel_irq
);
    import dmcc_pkg::*;

    logic [15:0]  dma_channel_control;
    logic [1:0]   request_source;
    logic         global_master_enable;
    logic [31:0]  src_addr;
    logic [`DMCC_COUNT_W-1:0] remaining_count;
    logic         done_read_armed;
    logic         busy;
    logic [1:0]   beat;
    logic         ph_write;
    logic [11:0]  ph_addr;
    logic [31:0]  next_src_addr;
    logic [31:0]  rd_mux;
    logic         pin_hit;
    logic         req_hit;
    logic         can_run;
    logic         wr_ctrl;
    logic         done_set;
    logic         ack_active;
    dmcc_step_type src_addr_step_mode;
    dmcc_size_type transfer_unit_size;

    assign src_addr_step_mode = dmcc_step_type'(dma_channel_control[`DMCC_SM_HI:`DMCC_SM_LO]);
    assign transfer_unit_size = dmcc_size_type'(dma_channel_control[`DMCC_TS_HI:`DMCC_TS_LO]);

    wire self_request_select   = dma_channel_control[`DMCC_BIT_AR];
    wire ack_phase_select      = dma_channel_control[`DMCC_BIT_AM];
    wire ack_polarity          = dma_channel_control[`DMCC_BIT_AL];
    wire request_sense_select  = dma_channel_control[`DMCC_BIT_DS];
    wire request_polarity      = dma_channel_control[`DMCC_BIT_DL];
    wire bus_hold_mode         = dma_channel_control[`DMCC_BIT_TB];
    wire address_scheme_select = dma_channel_control[`DMCC_BIT_TA];
    wire channel_irq_enable    = dma_channel_control[`DMCC_BIT_IE];
    wire transfer_done_flag    = dma_channel_control[`DMCC_BIT_TE];
    wire channel_enable        = dma_channel_control[`DMCC_BIT_DE];

    // address phase capture; zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_write <= 1'b0;
            ph_addr  <= 12'h000;
        end
        else if (hready)
        begin
            ph_write <= hsel & htrans[1] & hwrite;
            ph_addr  <= haddr[11:0];
        end
    end

    wire rd_take = hsel & htrans[1] & ~hwrite & hready;
    assign wr_ctrl = ph_write & (ph_addr == `DMCC_OFS_CTRL);

    always_comb
    begin
        case (haddr[11:0])
            `DMCC_OFS_CTRL:   rd_mux = {16'h0000, dma_channel_control};
            `DMCC_OFS_SRC:    rd_mux = {30'h00000000, request_source};
            `DMCC_OFS_GLOBAL: rd_mux = {31'h00000000, global_master_enable};
            `DMCC_OFS_SADDR:  rd_mux = src_addr;
            `DMCC_OFS_COUNT:  rd_mux = {8'h00, remaining_count};
            `DMCC_OFS_STATUS: rd_mux = {28'h0000000, beat, busy, req_hit};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (rd_take)
            hrdata <= rd_mux;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read of the flag as one arms the clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            done_read_armed <= 1'b0;
        else if (rd_take && haddr[11:0] == `DMCC_OFS_CTRL && transfer_done_flag)
            done_read_armed <= 1'b1;
        else if (wr_ctrl)
            done_read_armed <= 1'b0;
    end

    assign done_set = busy & xfer_done & ~xfer_abort & (beat == 2'h0)
                    & (remaining_count == `DMCC_COUNT_W'(1));

    // control register; flag bit only by hardware set or armed zero write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dma_channel_control <= `DMCC_CTRL_RESET;
        else
        begin
            if (wr_ctrl)
                dma_channel_control <= (hwdata[15:0] & `DMCC_CTRL_WMASK)
                                     | (dma_channel_control & ~`DMCC_CTRL_WMASK);
            if (wr_ctrl && done_read_armed && !hwdata[`DMCC_BIT_TE])
                dma_channel_control[`DMCC_BIT_TE] <= 1'b0;
            // set wins over a simultaneous clear
            if (done_set)
                dma_channel_control[`DMCC_BIT_TE] <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            request_source <= `DMCC_SRC_RESET;
        else if (ph_write && ph_addr == `DMCC_OFS_SRC)
            request_source <= hwdata[1:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            global_master_enable <= 1'b0;
        else if (ph_write && ph_addr == `DMCC_OFS_GLOBAL)
            global_master_enable <= hwdata[0];
    end

    dmcc_req_detect u_detect
    (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .sense_edge  (request_sense_select),
        .active_high (request_polarity),
        .req_in      (external_request_pin),
        .req_hit     (pin_hit)
    );

    always_comb
    begin
        case (dmcc_src_type'(request_source))
            DMCC_RS_PIN:     req_hit = pin_hit;
            DMCC_RS_RXFULL:  req_hit = serial_rx_full_req;
            DMCC_RS_TXEMPTY: req_hit = serial_tx_empty_req;
            default:         req_hit = 1'b0;
        endcase
    end

    // all gates must be open and the done flag clear
    assign can_run = channel_enable & global_master_enable & ~transfer_done_flag
                   & (remaining_count != `DMCC_COUNT_W'(0));

    dmcc_addr_step u_step
    (
        .mode     (src_addr_step_mode),
        .size     (transfer_unit_size),
        .addr_in  (src_addr),
        .addr_out (next_src_addr)
    );

    // sequencer: a 16-byte unit walks four longword beats
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy       <= 1'b0;
            beat       <= 2'h0;
            xfer_start <= 1'b0;
        end
        else
        begin
            xfer_start <= 1'b0;
            if (!busy)
            begin
                if (can_run && (self_request_select || req_hit))
                begin
                    busy       <= 1'b1;
                    beat       <= (transfer_unit_size == DMCC_TS_16B) ? `DMCC_BEATS_16B : 2'h0;
                    xfer_start <= 1'b1;
                end
            end
            else if (xfer_abort)
            begin
                busy <= 1'b0;
                beat <= 2'h0;
            end
            else if (xfer_done)
            begin
                if (beat != 2'h0)
                begin
                    beat       <= beat - 2'h1;
                    xfer_start <= 1'b1;
                end
                else
                    busy <= 1'b0;
            end
        end
    end

    // source address and count; address steps per unit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            src_addr        <= 32'h00000000;
            remaining_count <= `DMCC_COUNT_W'(0);
        end
        else if (ph_write && ph_addr == `DMCC_OFS_SADDR)
            src_addr <= hwdata;
        else if (ph_write && ph_addr == `DMCC_OFS_COUNT)
            remaining_count <= hwdata[`DMCC_COUNT_W-1:0];
        else if (busy && xfer_done && !xfer_abort && beat == 2'h0)
        begin
            src_addr        <= next_src_addr;
            remaining_count <= remaining_count - `DMCC_COUNT_W'(1);
        end
    end

    // acknowledge is asserted in the chosen cycle phase
    // start cycle is the read half of a beat, the rest its write half
    logic         in_write_half;
    assign in_write_half = ~xfer_start;
    assign ack_active    = busy & (ack_phase_select ? in_write_half : ~in_write_half);


    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dma_acknowledge_pin <= 1'b1;
            xfer_is_write       <= 1'b0;
            xfer_src_addr       <= 32'h00000000;
            bus_hold            <= 1'b0;
            single_address      <= 1'b0;
            channel_irq         <= 1'b0;
        end
        else
        begin
            dma_acknowledge_pin <= ack_polarity ? ack_active : ~ack_active;
            xfer_is_write       <= ack_phase_select;
            xfer_src_addr       <= src_addr;
            bus_hold            <= busy & bus_hold_mode;
            single_address      <= address_scheme_select;
            channel_irq         <= channel_irq_enable & transfer_done_flag;
        end
    end

    a_flag_on_end: assert property (@(posedge hclk) disable iff (!hresetn)
        done_set |=> transfer_done_flag)
        else $error("done flag not set at count end");
    a_flag_only_end: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(transfer_done_flag) |-> $past(done_set))
        else $error("done flag set without count end");
    a_clear_needs_read: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(transfer_done_flag) |-> $past(done_read_armed))
        else $error("done flag cleared without prior read");
    a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn)
        !channel_irq_enable |=> !channel_irq)
        else $error("interrupt without enable");
    a_master_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        !global_master_enable && !busy |=> !xfer_start)
        else $error("start while master enable clear");
    a_src_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take && haddr[11:0] == `DMCC_OFS_SRC |=> hrdata[31:2] == 30'h00000000)
        else $error("request source upper bits nonzero");
    a_count_dec: assert property (@(posedge hclk) disable iff (!hresetn)
        busy && xfer_done && !xfer_abort && beat == 2'h0 && !ph_write
        |=> remaining_count == $past(remaining_count) - `DMCC_COUNT_W'(1))
        else $error("count did not decrement");
    sequence s_unit16_start;
        !busy && xfer_start == 1'b0 && can_run && self_request_select && transfer_unit_size == DMCC_TS_16B;
    endsequence
    a_four_beats: assert property (@(posedge hclk) disable iff (!hresetn)
        s_unit16_start |=> beat == `DMCC_BEATS_16B)
        else $error("16-byte unit not four beats");
    a_ack_level: assert property (@(posedge hclk) disable iff (!hresetn)
        !busy && !$past(busy) |=> dma_acknowledge_pin == !ack_polarity || $changed(ack_polarity))
        else $error("idle ack level wrong");
endmodule // dmcc_channel

// *** test/dmcc_peripheral.sv ***
// external peripheral model: drives the request pin, watches the acknowledge
`timescale 1ns/1ps
module dmcc_peripheral
(
    // clock
    input  wire logic  hclk,
    // settings from the bench
    input  wire logic  req_on,
    input  wire logic  active_high,
    input  wire logic  ack_high,
    // pins
    output logic       external_request_pin,
    input  wire logic  dma_acknowledge_pin,
    // observation
    output logic [7:0] ack_count
);
    logic acked = 1'b0;

    initial ack_count = 8'h00;

    // request held until acknowledged, then back to the idle level
    assign external_request_pin = (req_on && !acked) ? active_high : !active_high;

    // acknowledge counted in the polarity the bench expects
    always @(posedge hclk)
    begin
        if (!req_on)
            acked <= 1'b0;
        else if (dma_acknowledge_pin === ack_high)
        begin
            acked     <= 1'b1;
            ack_count <= ack_count + 8'h01;
        end
    end
endmodule // dmcc_peripheral

// *** test/testbench.sv ***
// self-checking bench for the dma channel mode control block
`timescale 1ns/1ps
`include "dmcc_params.svh"
module testbench;
    import dmcc_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, expv;
    logic [1:0]  htrans = 2'h0, mm, ss;
    logic [2:0]  hsize = 3'h0;
    logic        rx_req = 1'b0, tx_req = 1'b0, xfer_done = 1'b0, xfer_abort = 1'b0;
    logic        req_on = 1'b0, act_high = 1'b0, ack_high = 1'b0, abort_next = 1'b0, hold_seen = 1'b0;
    logic [2:0]  dly = 3'h0;
    logic [15:0] c;
    logic [7:0]  ack_count, a0;
    wire  [31:0] hrdata, src_q;
    wire         hreadyout, xfer_start, xfer_is_write, bus_hold, single_address, ack_pin, channel_irq, ext_req;
    int          miscompares = 0, total_checks = 0, starts = 0, st0, i, m, s;

    always #50 hclk = ~hclk;

    dmcc_channel uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .external_request_pin(ext_req), .serial_rx_full_req(rx_req),
        .serial_tx_empty_req(tx_req), .xfer_done(xfer_done), .xfer_abort(xfer_abort),
        .xfer_start(xfer_start), .xfer_is_write(xfer_is_write), .xfer_src_addr(src_q),
        .bus_hold(bus_hold), .single_address(single_address), .dma_acknowledge_pin(ack_pin),
        .channel_irq(channel_irq));

    dmcc_peripheral peer (.hclk(hclk), .req_on(req_on), .active_high(act_high), .ack_high(ack_high),
        .external_request_pin(ext_req), .dma_acknowledge_pin(ack_pin), .ack_count(ack_count));

    // engine stand-in: each beat finishes six cycles after it starts
    always @(posedge hclk)
    begin
        xfer_done  <= 1'b0;
        xfer_abort <= 1'b0;
        if (bus_hold === 1'b1)
            hold_seen <= 1'b1;
        if (xfer_start === 1'b1)
        begin
            starts <= starts + 1;
            dly    <= 3'h6;
        end
        else if (dly == 3'h1)
        begin
            if (abort_next)
                xfer_abort <= 1'b1;
            else
                xfer_done <= 1'b1;
            abort_next <= 1'b0;
            dly        <= 3'h0;
        end
        else if (dly != 3'h0)
            dly <= dly - 3'h1;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single ahb-lite transfer; read data lands in rd
    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // polls the count, not the control word, so no clear is armed
    task wait_count0;
        for (i = 0; i < 300; i++)
        begin
            bus(1'b0, `DMCC_OFS_COUNT, 32'h0);
            if (rd === 32'h0)
                break;
        end
        if (i == 300)
            miscompares++;
        repeat (2) @(posedge hclk);
    endtask

    task clear_te(input logic [15:0] cv);
        bus(1'b0, `DMCC_OFS_CTRL, 32'h0);
        wr(`DMCC_OFS_CTRL, {16'h0, cv & 16'hfffd});
        rdc(`DMCC_OFS_CTRL, {16'h0, cv & 16'hfffd});
    endtask

    task end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, miscompares);
    endtask

    task print_verdict;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #5_000_000;
        miscompares++;
        print_verdict;
    end

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(`DMCC_OFS_CTRL, 32'h0);
        rdc(`DMCC_OFS_SRC, 32'h0);
        rdc(12'h020, 32'h0);
        wr(`DMCC_OFS_SRC, 32'hff);
        rdc(`DMCC_OFS_SRC, 32'h3);
        end_test("reset");
        // global enable still clear: nothing may start
        wr(`DMCC_OFS_COUNT, 32'h2);
        wr(`DMCC_OFS_CTRL, 32'h0201);
        repeat (30) @(posedge hclk);
        chk(starts, 0);
        // channel disabled first, so the armed count cannot start once the master gate opens
        wr(`DMCC_OFS_CTRL, 32'h0200);
        wr(`DMCC_OFS_GLOBAL, 32'h1);
        repeat (30) @(posedge hclk);
        chk(starts, 0);
        end_test("enables");
        // step mode stays within 00..10, never the reserved pattern
        for (m = 0; m < 3; m++)
            for (s = 0; s < 4; s++)
            begin
                mm = m[1:0];
                ss = s[1:0];
                c = {2'b00, mm, ss, 1'b1, ss[0], mm[0], 2'b00, mm[0] ^ ss[0], ss[1], ss[1] ^ mm[0], 2'b01};
                expv = (s == 3) ? 32'h10 : (m == 0) ? 32'h0 : (32'h1 << s);
                expv = (m == 2 && s != 3) ? 32'h1000 - 2 * expv : 32'h1000 + 2 * expv;
                hold_seen = 1'b0;
                st0 = starts;
                // mode first, count last: a count under the old mode would start at once
                wr(`DMCC_OFS_SADDR, 32'h1000);
                wr(`DMCC_OFS_CTRL, {16'h0, c});
                wr(`DMCC_OFS_COUNT, 32'h2);
                wait_count0;
                rdc(`DMCC_OFS_SADDR, expv);
                chk(src_q, expv);
                chk(starts - st0, (s == 3) ? 8 : 2);
                chk({31'h0, channel_irq}, {31'h0, c[2]});
                chk({31'h0, xfer_is_write}, {31'h0, c[8]});
                chk({31'h0, single_address}, {31'h0, c[3]});
                chk({31'h0, hold_seen}, {31'h0, c[4]});
                if (m == 0 && s == 0)
                begin
                    wr(`DMCC_OFS_CTRL, {16'h0, c});
                end
                rdc(`DMCC_OFS_CTRL, {16'h0, c | 16'h2});
                clear_te(c);
            end
        end_test("steps");
        for (m = 0; m < 4; m++)
        begin
            mm = m[1:0];
            act_high <= mm[0];
            ack_high <= mm[0] ^ mm[1];
            c = {8'h0, mm[0] ^ mm[1], mm[1], mm[0], 5'h01};
            st0 = starts;
            wr(`DMCC_OFS_SRC, 32'h0);
            wr(`DMCC_OFS_CTRL, {16'h0, c});
            wr(`DMCC_OFS_COUNT, 32'h1);
            repeat (20) @(posedge hclk);
            chk(starts, st0);
            a0 = ack_count;
            req_on <= 1'b1;
            wait_count0;
            chk({31'h0, ack_count != a0}, 32'h1);
            chk({31'h0, ack_pin}, {31'h0, !ack_high});
            req_on <= 1'b0;
            clear_te(c);
        end
        end_test("pin");
        for (m = 1; m < 3; m++)
        begin
            wr(`DMCC_OFS_SRC, m);
            wr(`DMCC_OFS_COUNT, 32'h1);
            wr(`DMCC_OFS_CTRL, 32'h1);
            rx_req <= (m == 1);
            tx_req <= (m == 2);
            wait_count0;
            rdc(`DMCC_OFS_CTRL, 32'h3);
            rx_req <= 1'b0;
            tx_req <= 1'b0;
            clear_te(16'h1);
        end
        end_test("sources");
        abort_next = 1'b1;
        wr(`DMCC_OFS_COUNT, 32'h2);
        wr(`DMCC_OFS_CTRL, 32'h0201);
        for (i = 0; i < 100 && xfer_abort !== 1'b1; i++)
            @(posedge hclk);
        rdc(`DMCC_OFS_COUNT, 32'h2);
        rdc(`DMCC_OFS_CTRL, 32'h0201);
        wait_count0;
        clear_te(16'h0);
        end_test("abort");
        print_verdict;
    end
endmodule // testbench
